// >>> hdl/smc_pkg.sv
package smc_pkg;
  // quality check: oscillator cycles of good clock before it is trusted
  localparam int unsigned QC_OSC_CYCLES = 4096;
  localparam logic [12:0] QC_COUNT_LAST = 13'(QC_OSC_CYCLES - 1);
  // full-stop wake-up: most check windows before giving up
  localparam int unsigned WAKE_CHECK_WINDOWS = 50;
  localparam logic [5:0] WAKE_WINDOW_LAST = 6'(WAKE_CHECK_WINDOWS - 1);
  // length of one check window in system clock cycles
  localparam int unsigned CHECK_WINDOW_CYCLES = 256;
  localparam logic [8:0] CHECK_WINDOW_LAST = 9'(CHECK_WINDOW_CYCLES - 1);
  // reset values of configuration bits
  localparam logic CME_RESET = 1'b1;
  localparam logic SELF_CLOCK_MODE_ENABLE_RESET = 1'b1;
  localparam logic SELF_CLOCK_IRQ_ENABLE_RESET = 1'b0;
  localparam logic PSEUDO_STOP_SELECT_RESET = 1'b0;
  localparam logic PLL_CLOCK_SELECT_RESET = 1'b0;

  typedef enum {
    SMC_RUN,
    SMC_CLR_PLL_CLOCK_SELECT,
    SMC_PLL_OFF,
    SMC_CORE_OFF,
    SMC_SYS_OFF,
    SMC_STOPPED,
    SMC_WAKE_CHECK
  } smc_state_e;
endpackage

// >>> hdl/smc_quality_checker.sv
// counts consecutive good oscillator cycles; restarts on any failure
module smc_quality_checker
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_osc_tick,
  input wire logic i_osc_fail,
  output logic o_busy,
  output logic o_good
);
  logic [12:0] count_reg;
  logic busy_reg;
  logic good_reg;

  // a fail restarts the count rather than ending the check
  always_ff @(posedge clk) begin
    if (!rst_n || i_abort) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
    end else if (i_start) begin
      count_reg <= '0;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (i_osc_fail) begin
        count_reg <= '0;
      end else if (i_osc_tick) begin
        if (count_reg == QC_COUNT_LAST) begin
          busy_reg <= 1'b0;
        end
        count_reg <= count_reg + 13'h1;
      end
    end
  end

  // one-cycle pulse when a check passes
  always_ff @(posedge clk) begin
    if (!rst_n || i_abort || i_start) begin
      good_reg <= 1'b0;
    end else begin
      good_reg <= busy_reg && !i_osc_fail && i_osc_tick &&
        count_reg == QC_COUNT_LAST;
    end
  end

  assign o_busy = busy_reg;
  assign o_good = good_reg;
endmodule

// >>> hdl/smc_stop_ctrl.sv
// Notes on behaviour
// - wait loss with monitor, self-clock, irq on: PLL, regulator on, flag
// - after self-clock irq leave wait on PLL, keep checking quality
// - stop halts clocks except pseudo-stop, REAL_TIME_INTERRUPT and watchdog keepers
// - oscillator off in full stop; REAL_TIME_INTERRUPT, watchdog clocks stop too
// - stop also asks regulator and others to enter low power
// - stop request clears PLL select so clocks run from oscillator
// - disable PLL, core clock, system clocks; then stop is active
// - pseudo-stop from self-clock keeps checking, PLL and regulator on
// - full stop from self-clock aborts check, full window check on exit
// - external reset in pseudo-stop resets config, starts reset generator
// - monitor disabled: clock loss in pseudo-stop is ignored
// - monitor on, self-clock off: loss gives clock monitor reset
// - self-clock and irq on: irq, self-clock, check, wake
// - self-clock on, irq off: flag, self-clock, check, no wake
// - oscillator recovers: good after 4096 cycles, PLL off, stay stopped
// - after recovery wake or reset exits on oscillator clock
// - no recovery: quality checks repeat without limit in pseudo-stop
// - no recovery: wake interrupt exits on PLL self-clock
// - no recovery: external reset exits on self-clock, checks go on
// - other interrupts wake pseudo-stop at once, PLL select cleared
// - full stop wake-up runs at most 50 check windows first
// - all windows fail: self-clock or monitor reset per enable bit
module smc_stop_ctrl
  import smc_pkg::*;
(
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // core requests and wake-up events
  input wire logic I_STOP_REQ,
  input wire logic I_WAIT_ACTIVE,
  input wire logic I_WAKE_IRQ,
  input wire logic I_EXT_RESET_N,
  // configuration bits
  input wire logic I_CLOCK_MONITOR_ENABLE,
  input wire logic I_SELF_CLOCK_MODE_ENABLE,
  input wire logic I_SELF_CLOCK_IRQ_ENABLE,
  input wire logic I_PSEUDO_STOP_SELECT,
  input wire logic I_RTI_RUN_IN_STOP,
  input wire logic I_WATCHDOG_RUN_IN_STOP,
  input wire logic I_PLL_SELECT_SET,
  input wire logic I_FLAG_CLEAR,
  // oscillator monitor
  input wire logic I_OSC_TICK,
  input wire logic I_OSC_FAIL,
  // clock and power controls
  output logic O_PLL_CLOCK_SELECT,
  output logic O_PLL_ENABLE,
  output logic O_CORE_CLK_EN,
  output logic O_SYS_CLK_EN,
  output logic O_OSC_ENABLE,
  output logic O_RTI_CLK_EN,
  output logic O_WATCHDOG_CLK_EN,
  output logic O_REGULATOR_LOW_POWER,
  output logic O_STOP_ACTIVE,
  // status and events
  output logic O_SELF_CLOCK_MODE,
  output logic O_SELF_CLOCK_IRQ_FLAG,
  output logic O_SELF_CLOCK_IRQ,
  output logic O_CLOCK_MONITOR_FAIL_RESET,
  output logic O_RESET_GEN_START,
  output logic O_CONFIG_DEFAULTS
);
  smc_state_e state_reg;
  smc_state_e state_next;
  logic stop_s1_reg, stop_s2_reg;
  logic wake_s1_reg, wake_s2_reg;
  logic xrst_s1_reg, xrst_s2_reg;
  logic fail_s1_reg, fail_s2_reg;
  logic tick_s1_reg, tick_s2_reg, tick_d_reg;
  logic pll_clock_select_reg, pll_en_reg, core_en_reg, sys_en_reg, osc_en_reg;
  logic rti_en_reg, wdg_en_reg, voltage_regulator_lp_reg, stop_act_reg;
  logic scm_reg, flag_reg, irq_reg, cmrst_reg, rstgen_reg, cfgdef_reg;
  logic full_stop_pending_reg;
  logic [8:0] win_cnt_reg;
  logic [5:0] win_num_reg;
  logic qc_busy, qc_good, qc_start, qc_abort;
  logic osc_tick, osc_fail, stop_req, wake_irq, ext_reset;
  logic loss_evt, in_pstop, all_windows_failed;
  logic in_fstop, full_stop_ahead;

  // two-flop synchronisers for the stop, wake, external reset and oscillator inputs
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      xrst_s1_reg <= 1'b0;
      xrst_s2_reg <= 1'b0;
      fail_s1_reg <= 1'b0;
      fail_s2_reg <= 1'b0;
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_d_reg <= 1'b0;
    end else begin
      stop_s1_reg <= I_STOP_REQ;
      stop_s2_reg <= stop_s1_reg;
      wake_s1_reg <= I_WAKE_IRQ;
      wake_s2_reg <= wake_s1_reg;
      xrst_s1_reg <= !I_EXT_RESET_N;
      xrst_s2_reg <= xrst_s1_reg;
      fail_s1_reg <= I_OSC_FAIL;
      fail_s2_reg <= fail_s1_reg;
      tick_s1_reg <= I_OSC_TICK;
      tick_s2_reg <= tick_s1_reg;
      tick_d_reg <= tick_s2_reg;
    end
  end

  assign stop_req = stop_s2_reg;
  assign wake_irq = wake_s2_reg;
  assign ext_reset = xrst_s2_reg;
  assign osc_fail = fail_s2_reg;
  assign osc_tick = tick_s2_reg && !tick_d_reg; // rising edge = one cycle
  assign in_pstop = state_reg == SMC_STOPPED && I_PSEUDO_STOP_SELECT;
  assign in_fstop = state_reg == SMC_STOPPED && !I_PSEUDO_STOP_SELECT;
  // full stop lets the pll go even from self-clock; nothing runs on it then
  assign full_stop_ahead = state_next == SMC_STOPPED &&
    !I_PSEUDO_STOP_SELECT;
  // loss only seen when the monitor runs; full stop disables it
  assign loss_evt = osc_fail && I_CLOCK_MONITOR_ENABLE && !scm_reg &&
    (in_pstop || I_WAIT_ACTIVE);
  assign all_windows_failed = state_reg == SMC_WAKE_CHECK &&
    win_num_reg == WAKE_WINDOW_LAST && win_cnt_reg == CHECK_WINDOW_LAST;

  // quality check starts on self-clock entry and each full-stop wake;
  // no self-clock retry in full stop, the oscillator is off there
  assign qc_start = (loss_evt && I_SELF_CLOCK_MODE_ENABLE) ||
    (in_fstop && (wake_irq || ext_reset)) ||
    (scm_reg && !in_fstop && !qc_busy && !qc_good);
  // full stop from self-clock drops an ongoing check
  assign qc_abort = state_reg == SMC_SYS_OFF && !I_PSEUDO_STOP_SELECT;

  smc_quality_checker u_qc (
    .clk(I_SYS_CLK),
    .rst_n(I_RESETN),
    .i_start(qc_start),
    .i_abort(qc_abort),
    .i_osc_tick(osc_tick),
    .i_osc_fail(osc_fail),
    .o_busy(qc_busy),
    .o_good(qc_good)
  );

  // state register
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      state_reg <= SMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // stop entry walks the clocks down one step per cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SMC_RUN: begin
        if (stop_req) begin
          state_next = SMC_CLR_PLL_CLOCK_SELECT;
        end
      end
      SMC_CLR_PLL_CLOCK_SELECT: state_next = SMC_PLL_OFF;
      SMC_PLL_OFF: state_next = SMC_CORE_OFF;
      SMC_CORE_OFF: state_next = SMC_SYS_OFF;
      SMC_SYS_OFF: state_next = SMC_STOPPED;
      SMC_STOPPED: begin
        if (I_PSEUDO_STOP_SELECT) begin
          if (wake_irq || ext_reset) begin
            state_next = SMC_RUN;
          end else if (loss_evt && I_SELF_CLOCK_MODE_ENABLE &&
                       I_SELF_CLOCK_IRQ_ENABLE) begin
            state_next = SMC_RUN;
          end else if (loss_evt && !I_SELF_CLOCK_MODE_ENABLE) begin
            state_next = SMC_RUN;
          end
        end else if (wake_irq || ext_reset) begin
          state_next = SMC_WAKE_CHECK;
        end
      end
      SMC_WAKE_CHECK: begin
        if (qc_good || all_windows_failed) begin
          state_next = SMC_RUN;
        end
      end
      default: state_next = SMC_RUN;
    endcase
  end

  // check-window timer for the full-stop wake-up
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN || state_reg != SMC_WAKE_CHECK) begin
      win_cnt_reg <= '0;
      win_num_reg <= '0;
    end else if (win_cnt_reg == CHECK_WINDOW_LAST) begin
      win_cnt_reg <= '0;
      win_num_reg <= win_num_reg + 6'h1;
    end else begin
      win_cnt_reg <= win_cnt_reg + 9'h1;
    end
  end

  // remember whether the pending wake came from external reset
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN || state_reg == SMC_RUN) begin
      full_stop_pending_reg <= 1'b0;
    end else if (state_reg == SMC_STOPPED && ext_reset) begin
      full_stop_pending_reg <= 1'b1;
    end
  end

  // pll select: cleared on stop, set again only by software
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      pll_clock_select_reg <= PLL_CLOCK_SELECT_RESET;
    end else if (state_reg == SMC_CLR_PLL_CLOCK_SELECT || ext_reset ||
                 state_reg != SMC_RUN) begin
      pll_clock_select_reg <= 1'b0;
    end else if (I_PLL_SELECT_SET && !scm_reg) begin
      pll_clock_select_reg <= 1'b1;
    end
  end

  // self-clock mode: entered on loss or failed windows, left on a good check
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      scm_reg <= 1'b0;
    end else if (loss_evt && I_SELF_CLOCK_MODE_ENABLE) begin
      scm_reg <= 1'b1;
    end else if (all_windows_failed && I_SELF_CLOCK_MODE_ENABLE) begin
      scm_reg <= 1'b1;
    end else if (qc_good) begin
      scm_reg <= 1'b0;
    end
  end

  // sticky flag; a new event beats a clear in the same cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      flag_reg <= 1'b0;
    end else if (loss_evt && I_SELF_CLOCK_MODE_ENABLE) begin
      flag_reg <= 1'b1;
    end else if (I_FLAG_CLEAR) begin
      flag_reg <= 1'b0;
    end
  end

  // one-cycle interrupt pulse only when the irq is enabled
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= loss_evt && I_SELF_CLOCK_MODE_ENABLE &&
        I_SELF_CLOCK_IRQ_ENABLE;
    end
  end

  // reset requests: monitor reset, reset generator start, config defaults
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      cmrst_reg <= 1'b0;
      rstgen_reg <= 1'b0;
      cfgdef_reg <= 1'b0;
    end else begin
      cmrst_reg <= (loss_evt && !I_SELF_CLOCK_MODE_ENABLE) ||
        (all_windows_failed && !I_SELF_CLOCK_MODE_ENABLE);
      // in full stop the reset generator waits for the check windows
      rstgen_reg <= (in_pstop && ext_reset) ||
        (loss_evt && !I_SELF_CLOCK_MODE_ENABLE) ||
        (state_reg == SMC_WAKE_CHECK && full_stop_pending_reg &&
         (qc_good || all_windows_failed));
      cfgdef_reg <= ext_reset;
    end
  end

  // pll and regulator: held up while self-clocking, except in full stop
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      pll_en_reg <= 1'b1;
      voltage_regulator_lp_reg <= 1'b0;
    end else begin
      // self-clock still needs the pll until the last gate has closed
      pll_en_reg <= (scm_reg && !full_stop_ahead) || state_next == SMC_RUN ||
        state_next == SMC_CLR_PLL_CLOCK_SELECT;
      voltage_regulator_lp_reg <= state_next == SMC_STOPPED &&
        (!scm_reg || !I_PSEUDO_STOP_SELECT);
    end
  end

  // core and system clock gates, taken down one step per cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      core_en_reg <= 1'b1;
      sys_en_reg <= 1'b1;
      stop_act_reg <= 1'b0;
    end else begin
      core_en_reg <= state_next == SMC_RUN ||
        state_next == SMC_CLR_PLL_CLOCK_SELECT || state_next == SMC_PLL_OFF;
      sys_en_reg <= state_next == SMC_RUN ||
        state_next == SMC_CLR_PLL_CLOCK_SELECT || state_next == SMC_PLL_OFF ||
        state_next == SMC_CORE_OFF;
      // stop is reported only once the last gate has closed
      stop_act_reg <= state_next == SMC_STOPPED;
    end
  end

  // keepers: oscillator, rti and watchdog clocks through stop
  // the oscillator stays up in pseudo-stop so the monitor can see a loss
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      osc_en_reg <= 1'b1;
      rti_en_reg <= 1'b1;
      wdg_en_reg <= 1'b1;
    end else begin
      osc_en_reg <= state_next != SMC_STOPPED ||
        I_PSEUDO_STOP_SELECT;
      rti_en_reg <= state_next != SMC_STOPPED ||
        (I_PSEUDO_STOP_SELECT && I_RTI_RUN_IN_STOP);
      wdg_en_reg <= state_next != SMC_STOPPED ||
        (I_PSEUDO_STOP_SELECT && I_WATCHDOG_RUN_IN_STOP);
    end
  end

  assign O_PLL_CLOCK_SELECT = pll_clock_select_reg;
  assign O_PLL_ENABLE = pll_en_reg;
  assign O_CORE_CLK_EN = core_en_reg;
  assign O_SYS_CLK_EN = sys_en_reg;
  assign O_OSC_ENABLE = osc_en_reg;
  assign O_RTI_CLK_EN = rti_en_reg;
  assign O_WATCHDOG_CLK_EN = wdg_en_reg;
  assign O_REGULATOR_LOW_POWER = voltage_regulator_lp_reg;
  assign O_STOP_ACTIVE = stop_act_reg;
  assign O_SELF_CLOCK_MODE = scm_reg;
  assign O_SELF_CLOCK_IRQ_FLAG = flag_reg;
  assign O_SELF_CLOCK_IRQ = irq_reg;
  assign O_CLOCK_MONITOR_FAIL_RESET = cmrst_reg;
  assign O_RESET_GEN_START = rstgen_reg;
  assign O_CONFIG_DEFAULTS = cfgdef_reg;
endmodule

// >>> verification/smc_osc_model.sv
// oscillator and its monitor; a lost oscillator stands still
module smc_osc_model (
  input wire logic i_clk,
  input wire logic i_osc_ok,
  output logic o_tick,
  output logic o_fail
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_tick = 1'b0;
  initial o_fail = 1'b0;
  // one oscillator cycle per two system cycles while running
  always @(posedge i_clk) begin
    o_tick <= #1 i_osc_ok ? ~o_tick : o_tick;
    o_fail <= #1 ~i_osc_ok;
  end
endmodule

// >>> verification/smc_stop_checker.sv
module smc_stop_checker (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // inputs watched
  input wire logic I_FLAG_CLEAR,
  input wire logic I_PSEUDO_STOP_SELECT,
  input wire logic I_RTI_RUN_IN_STOP,
  input wire logic I_CLOCK_MONITOR_ENABLE,
  input wire logic I_SELF_CLOCK_MODE_ENABLE,
  input wire logic I_SELF_CLOCK_IRQ_ENABLE,
  // outputs watched
  input wire logic O_PLL_CLOCK_SELECT,
  input wire logic O_PLL_ENABLE,
  input wire logic O_CORE_CLK_EN,
  input wire logic O_SYS_CLK_EN,
  input wire logic O_OSC_ENABLE,
  input wire logic O_RTI_CLK_EN,
  input wire logic O_REGULATOR_LOW_POWER,
  input wire logic O_STOP_ACTIVE,
  input wire logic O_SELF_CLOCK_MODE,
  input wire logic O_SELF_CLOCK_IRQ_FLAG,
  input wire logic O_SELF_CLOCK_IRQ,
  input wire logic O_CLOCK_MONITOR_FAIL_RESET,
  input wire logic O_CONFIG_DEFAULTS
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);

  // gating order: pll first unless self-clocking, then core, then the rest
  property p_pll_before_core;
    $fell(O_CORE_CLK_EN) && !O_SELF_CLOCK_MODE |-> !O_PLL_ENABLE;
  endproperty
  a_pll_before_core: assert property (p_pll_before_core)
    else $error("core clock stopped with pll running");
  property p_core_before_sys;
    $fell(O_SYS_CLK_EN) |-> !O_CORE_CLK_EN;
  endproperty
  a_core_before_sys: assert property (p_core_before_sys)
    else $error("system clocks stopped before core clock");
  // stop is only reported once core and system clocks are gated and off the pll
  property p_stop_gated;
    O_STOP_ACTIVE |-> !O_CORE_CLK_EN && !O_SYS_CLK_EN && !O_PLL_CLOCK_SELECT;
  endproperty
  a_stop_gated: assert property (p_stop_gated)
    else $error("stop active with a clock still running");
  property p_osc_off;
    $rose(O_STOP_ACTIVE) && !I_PSEUDO_STOP_SELECT |-> !O_OSC_ENABLE;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator left on in full stop");
  property p_rti_keep;
    $rose(O_STOP_ACTIVE) && I_PSEUDO_STOP_SELECT
      |-> O_RTI_CLK_EN == I_RTI_RUN_IN_STOP;
  endproperty
  a_rti_keep: assert property (p_rti_keep)
    else $error("rti clock does not follow its stop enable");
  property p_low_power;
    $rose(O_STOP_ACTIVE) && !O_SELF_CLOCK_MODE
      |-> ##[0:2] O_REGULATOR_LOW_POWER;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("regulator not asked for low power in stop");
  // self-clock needs the pll and a full-power regulator, bar full stop
  property p_scm_pll;
    O_SELF_CLOCK_MODE [*2] ##0 (I_PSEUDO_STOP_SELECT || !O_STOP_ACTIVE)
      |-> O_PLL_ENABLE && !O_REGULATOR_LOW_POWER;
  endproperty
  a_scm_pll: assert property (p_scm_pll)
    else $error("self-clock without pll or regulator");
  property p_cm_reset;
    O_CLOCK_MONITOR_FAIL_RESET
      |-> $past(I_CLOCK_MONITOR_ENABLE) && !$past(I_SELF_CLOCK_MODE_ENABLE);
  endproperty
  a_cm_reset: assert property (p_cm_reset)
    else $error("monitor reset with wrong enables");
  property p_irq_gate;
    O_SELF_CLOCK_IRQ |-> $past(I_SELF_CLOCK_IRQ_ENABLE);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("self-clock interrupt while disabled");
  // clear may land a cycle late, so a recent clear is excused
  property p_flag_hold;
    O_SELF_CLOCK_IRQ_FLAG && !I_FLAG_CLEAR && !$past(I_FLAG_CLEAR)
      && !O_CONFIG_DEFAULTS |=> O_SELF_CLOCK_IRQ_FLAG;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("self-clock flag dropped without a clear");

  c_stop: cover property ($rose(O_STOP_ACTIVE));
  c_scm: cover property ($rose(O_SELF_CLOCK_MODE));
  c_cmr: cover property (O_CLOCK_MONITOR_FAIL_RESET);
endmodule

bind smc_stop_ctrl smc_stop_checker chk_u (.*);

// >>> verification/smc_stop_ctrl_tb.sv
module smc_stop_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STP = 8, SELF_CLOCK_MODE = 9, FLG = 10, IRQ = 11, CMR = 12, RGS = 13;
  logic clk = 1'b0, rst_n = 1'b0, stop = 1'b0, wake = 1'b0, ext_n = 1'b1;
  logic clock_monitor_enable = 1'b1, self_clock_mode_enable = 1'b1, self_clock_irq_enable = 1'b0, pseudo_stop_select = 1'b1, real_time_interrupt = 1'b1;
  logic wdg = 1'b0, pll_set = 1'b0, clr = 1'b0, osc_ok = 1'b1;
  logic tick, fail;
  wire [14:0] o;
  int fails = 0, n_tests = 0, cyc = 0;

  always #5 clk = ~clk;

  smc_stop_ctrl dut_u (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_STOP_REQ(stop),
    .I_WAIT_ACTIVE(1'b0), .I_WAKE_IRQ(wake), .I_EXT_RESET_N(ext_n),
    .I_CLOCK_MONITOR_ENABLE(clock_monitor_enable), .I_SELF_CLOCK_MODE_ENABLE(self_clock_mode_enable),
    .I_SELF_CLOCK_IRQ_ENABLE(self_clock_irq_enable), .I_PSEUDO_STOP_SELECT(pseudo_stop_select),
    .I_RTI_RUN_IN_STOP(real_time_interrupt), .I_WATCHDOG_RUN_IN_STOP(wdg),
    .I_PLL_SELECT_SET(pll_set), .I_FLAG_CLEAR(clr),
    .I_OSC_TICK(tick), .I_OSC_FAIL(fail),
    .O_PLL_CLOCK_SELECT(o[0]), .O_PLL_ENABLE(o[1]), .O_CORE_CLK_EN(o[2]),
    .O_SYS_CLK_EN(o[3]), .O_OSC_ENABLE(o[4]), .O_RTI_CLK_EN(o[5]),
    .O_WATCHDOG_CLK_EN(o[6]), .O_REGULATOR_LOW_POWER(o[7]),
    .O_STOP_ACTIVE(o[8]), .O_SELF_CLOCK_MODE(o[9]),
    .O_SELF_CLOCK_IRQ_FLAG(o[10]), .O_SELF_CLOCK_IRQ(o[11]),
    .O_CLOCK_MONITOR_FAIL_RESET(o[12]), .O_RESET_GEN_START(o[13]),
    .O_CONFIG_DEFAULTS(o[14]));

  smc_osc_model osc_u (.i_clk(clk), .i_osc_ok(osc_ok), .o_tick(tick),
    .o_fail(fail));

  // inputs always move 1 ns after the edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic a, input logic e);
    n_tests++;
    if (a !== e) begin
      $display("Error at %0t: got %h expected %h", $time, a, e);
      fails++;
    end
  endtask
  // polls every cycle so one-cycle pulses are not missed
  task wt(input int b, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && o[b] !== v; i++) step(1);
    chk(o[b], v);
  endtask
  task reset_all;
    rst_n = 1'b0;
    stop = 1'b0;
    wake = 1'b0;
    osc_ok = 1'b1;
    pseudo_stop_select = 1'b1;
    step(5);
    rst_n = 1'b1;
    step(1);
  endtask
  task enter_stop;
    stop = 1'b1;
    wt(STP, 1'b1, 20);
    stop = 1'b0;
    step(2);
  endtask
  // a full-stop wake ends stop early but holds clocks through the check
  task wake_up(input int lim);
    wake = 1'b1;
    wt(3, 1'b1, lim);
    chk(o[STP], 1'b0);
    wake = 1'b0;
    step(1);
  endtask
  task tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // pseudo-stop entry from the pll, then an ordinary wake-up
  task t_pseudo;
    pll_set = 1'b1;
    step(1);
    pll_set = 1'b0;
    step(2);
    chk(o[0], 1'b1);
    enter_stop;
    chk(o[0], 1'b0);
    chk(o[1] | o[2] | o[3], 1'b0);
    chk(o[4] & o[5], 1'b1);
    chk(o[6], 1'b0);
    chk(o[7], 1'b1);
    wake_up(20);
    chk(o[0], 1'b0);
    chk(o[2] & o[3], 1'b1);
  endtask
  // full stop: oscillator off, windowed wake-up, all windows failing
  task t_full;
    pseudo_stop_select = 1'b0;
    enter_stop;
    chk(o[4], 1'b0);
    wake_up(8400);
    enter_stop;
    osc_ok = 1'b0;
    wake = 1'b1;
    step(12000);
    chk(o[SELF_CLOCK_MODE], 1'b0);
    wt(SELF_CLOCK_MODE, 1'b1, 1500);
    wake = 1'b0;
    step(3);
    // full stop from self-clock: pll off, old check dropped
    enter_stop;
    chk(o[1], 1'b0);
    chk(o[7], 1'b1);
    osc_ok = 1'b1;
    wake_up(8400);
    chk(o[SELF_CLOCK_MODE], 1'b0);
  endtask
  // loss without wake: self-clock in stop, endless checks, recovery
  task t_loss_nowake;
    reset_all;
    enter_stop;
    osc_ok = 1'b0;
    wt(SELF_CLOCK_MODE, 1'b1, 10);
    chk(o[FLG], 1'b1);
    step(9000);
    chk(o[SELF_CLOCK_MODE] & o[STP] & o[1], 1'b1);
    chk(o[7], 1'b0);
    osc_ok = 1'b1;
    wt(SELF_CLOCK_MODE, 1'b0, 8400);
    step(2);
    chk(o[1], 1'b0);
    chk(o[7] & o[STP], 1'b1);
    chk(o[FLG], 1'b1);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(1);
    chk(o[FLG], 1'b0);
    wake_up(20);
    chk(o[SELF_CLOCK_MODE], 1'b0);
  endtask
  // loss with interrupt enabled wakes on the self-clock
  task t_loss_wake;
    reset_all;
    self_clock_irq_enable = 1'b1;
    enter_stop;
    osc_ok = 1'b0;
    wt(IRQ, 1'b1, 10);
    wt(STP, 1'b0, 10);
    chk(o[SELF_CLOCK_MODE], 1'b1);
    osc_ok = 1'b1;
    wt(SELF_CLOCK_MODE, 1'b0, 8400);
    self_clock_irq_enable = 1'b0;
  endtask
  // monitor off ignores the loss; monitor on without self-clock resets
  task t_loss_other;
    reset_all;
    clock_monitor_enable = 1'b0;
    enter_stop;
    osc_ok = 1'b0;
    step(30);
    chk(o[SELF_CLOCK_MODE], 1'b0);
    chk(o[STP], 1'b1);
    osc_ok = 1'b1;
    step(5);
    wake_up(20);
    clock_monitor_enable = 1'b1;
    self_clock_mode_enable = 1'b0;
    enter_stop;
    osc_ok = 1'b0;
    wt(CMR, 1'b1, 10);
    self_clock_mode_enable = 1'b1;
  endtask
  // external reset while in self-clock pseudo-stop
  task t_ext_reset;
    reset_all;
    enter_stop;
    osc_ok = 1'b0;
    wt(SELF_CLOCK_MODE, 1'b1, 10);
    ext_n = 1'b0;
    wt(RGS, 1'b1, 10);
    chk(o[14], 1'b1);
    wt(STP, 1'b0, 10);
    chk(o[SELF_CLOCK_MODE], 1'b1);
    ext_n = 1'b1;
    osc_ok = 1'b1;
    wt(SELF_CLOCK_MODE, 1'b0, 8400);
  endtask

  // hang guard, well above the roughly 63000 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      tally_and_finish;
    end
  end

  initial begin
    reset_all;
    t_pseudo;
    t_full;
    t_loss_nowake;
    t_loss_wake;
    t_loss_other;
    t_ext_reset;
    tally_and_finish;
  end
endmodule
